// ---- include/i2c_sleep_id_defs.vh ----
`ifndef I2C_SLEEP_ID_DEFS_VH
`define I2C_SLEEP_ID_DEFS_VH
`define RESERVED_SLAVE_BYTE 8'hF8
`define SLEEP_CMD_BYTE      8'h86
`define ID_READ_BYTE        8'hF9
`define DEV_TYPE_CODE       4'hA
`define ID_BYTES            2'h3
`define CLK_PERIOD_NS       40
`define TREC_US             400
`define TREC_CYCLES         ((`TREC_US * 1000) / `CLK_PERIOD_NS)
`endif

// ---- hw/i2c_sleep_id.v ----
`timescale 1ns/100ps
`include "i2c_sleep_id_defs.vh"
// Contract
// RQ1 - master sends start then F8h for sleep
// RQ2 - address word acked, top bit and rw ignored
// RQ3 - repeated start then 86h completes sleep
// RQ4 - ack 86h, then enter sleep, regulator off
// RQ5 - keep monitoring bus lines while sleeping
// RQ6 - master wakes with start plus address word
// RQ7 - recovery starts at ninth rising clock
// RQ8 - standby only after recovery time elapsed
// RQ9 - recovery lasts at most 400 us
// RQ10 - master starts fresh command after wake
// RQ11 - three byte fixed read-only identifier
// RQ12 - id read: start, F8h, address word
// RQ13 - repeated start then F9h starts readout
// RQ14 - send id bytes first, second, third
// RQ15 - nack ends read, ack wraps to first
// RQ16 - master releases data line, never drives high
// RQ17 - master recovers or retries on failure
// RQ18 - address word is 1010, selects, top bit, rw
// RQ19 - master toggles clock, then start and stop
// RQ20 - no ack during recovery; start aborts command
module i2c_sleep_id #(
   parameter         TREC_CYCLES = `TREC_CYCLES,
   parameter [23:0]  DEVICE_ID   = 24'h00A5C3
)(
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       scl_in,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe_n,
   input  wire       address_select_low,
   input  wire       address_select_high,
   output reg        regulator_on_q,
   output reg        sleeping_q,
   output reg        recovering_q
);
   // device id value is arbitrary

   localparam [2:0] PH_IDLE = 3'b001;
   localparam [2:0] PH_RX   = 3'b010;
   localparam [2:0] PH_TX   = 3'b100;
   // command progress
   localparam [1:0] C_NONE = 2'h0;
   localparam [1:0] C_RSV  = 2'h1;
   localparam [1:0] C_ADDR = 2'h2;
   localparam [1:0] C_ID   = 2'h3;

   reg [1:0]  scl_s_q, sda_s_q, sel_s_q;
   reg        scl_q, sda_q;
   reg [2:0]  ph_q;
   reg [3:0]  bit_q;
   reg [7:0]  sh_q;
   reg [1:0]  cmd_q;
   reg        ack_q;
   reg        drive_low_q;
   reg [1:0]  id_idx_q;
   reg [7:0]  tx_q;
   reg        master_ack_q;
   reg [31:0] rec_cnt_q;

   // two stages before any logic looks at the pins
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         sel_s_q <= 2'h0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         sel_s_q <= {sel_s_q[0], address_select_high};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end

   reg sel_lo_s0_q, sel_lo_q;
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sel_lo_s0_q <= 1'b0;
         sel_lo_q    <= 1'b0;
      end
      else
      begin
         sel_lo_s0_q <= address_select_low;
         sel_lo_q    <= sel_lo_s0_q;
      end
   end

   wire scl_rise = scl_s_q[1] & ~scl_q;
   wire scl_fall = ~scl_s_q[1] & scl_q;
   wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
   wire [7:0] rx_byte = {sh_q[6:0], sda_s_q[1]};
   // RQ18 address word match
   // judged on the held byte: the ninth rise would shift in the ack slot
   wire addr_hit = (sh_q[7:4] == `DEV_TYPE_CODE) &&
                   (sh_q[3] == sel_s_q[1]) &&
                   (sh_q[2] == sel_lo_q);

   // RQ11 fixed read-only three byte id
   wire [7:0] id_byte = (id_idx_q == 2'h0) ? DEVICE_ID[23:16] :
                        (id_idx_q == 2'h1) ? DEVICE_ID[15:8] :
                                             DEVICE_ID[7:0];

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         ph_q <= PH_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         cmd_q <= C_NONE;
         ack_q <= 1'b0;
         drive_low_q <= 1'b0;
         id_idx_q <= 2'h0;
         tx_q <= 8'hFF;
         master_ack_q <= 1'b0;
         regulator_on_q <= 1'b1;
         sleeping_q <= 1'b0;
         recovering_q <= 1'b0;
         rec_cnt_q <= 32'h0;
      end
      else
      begin
         // RQ9 bounded by TREC_CYCLES
         // RQ8 recovery wait then standby
         if (recovering_q)
         begin
            if (rec_cnt_q >= TREC_CYCLES - 1)
            begin
               recovering_q <= 1'b0;
               rec_cnt_q <= 32'h0;
            end
            else
               rec_cnt_q <= rec_cnt_q + 32'h1;
         end
         // RQ20 start aborts partial command, except one already at the acked address word (C_ADDR)
         if (start_c)
         begin
            ph_q <= PH_RX;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            drive_low_q <= 1'b0;
            if (cmd_q != C_ADDR)
               cmd_q <= C_NONE;
         end
         else if (stop_c)
         begin
            ph_q <= PH_IDLE;
            cmd_q <= C_NONE;
            drive_low_q <= 1'b0;
         end
         else if (ph_q == PH_RX)
         begin
            // RQ5 bus watched even while asleep
            if (scl_rise && bit_q < 4'h8)
            begin
               sh_q <= rx_byte;
               bit_q <= bit_q + 4'h1;
            end
            else if (scl_rise && bit_q == 4'h8)
            begin
               bit_q <= 4'h9;
               // RQ7 ninth rise starts recovery
               if (sleeping_q && addr_hit)
               begin
                  sleeping_q <= 1'b0;
                  recovering_q <= 1'b1;
                  regulator_on_q <= 1'b1;
                  rec_cnt_q <= 32'h0;
               end
            end
            else if (scl_fall && bit_q == 4'h8)
            begin
               ack_q <= 1'b0;
               // RQ20 silent while asleep or recovering
               if (!sleeping_q && !recovering_q)
               begin
                  if (sh_q == `RESERVED_SLAVE_BYTE)
                  begin
                     ack_q <= 1'b1;
                     cmd_q <= C_RSV;
                  end
                  // RQ2 top bit and rw ignored
                  else if (cmd_q == C_RSV && sh_q[7:4] == `DEV_TYPE_CODE
                           && sh_q[3] == sel_s_q[1]
                           && sh_q[2] == sel_lo_q)
                  begin
                     ack_q <= 1'b1;
                     cmd_q <= C_ADDR;
                  end
                  else if (cmd_q == C_ADDR &&
                           (sh_q == `SLEEP_CMD_BYTE ||
                            sh_q == `ID_READ_BYTE))
                  begin
                     ack_q <= 1'b1;
                     cmd_q <= (sh_q == `ID_READ_BYTE) ? C_ID : C_NONE;
                  end
                  else
                     cmd_q <= C_NONE;
               end
               drive_low_q <= !sleeping_q && !recovering_q &&
                  (sh_q == `RESERVED_SLAVE_BYTE ||
                   (cmd_q == C_RSV && sh_q[7:4] == `DEV_TYPE_CODE &&
                    sh_q[3] == sel_s_q[1] && sh_q[2] == sel_lo_q) ||
                   (cmd_q == C_ADDR && (sh_q == `SLEEP_CMD_BYTE ||
                                        sh_q == `ID_READ_BYTE)));
            end
            else if (scl_fall && bit_q == 4'h9)
            begin
               drive_low_q <= 1'b0;
               bit_q <= 4'h0;
               if (!ack_q)
                  ph_q <= PH_IDLE;
               // RQ4 sleep after the ack of 86h
               else if (sh_q == `SLEEP_CMD_BYTE)
               begin
                  sleeping_q <= 1'b1;
                  regulator_on_q <= 1'b0;
                  ph_q <= PH_IDLE;
               end
               // RQ14 first id byte follows F9h ack
               else if (cmd_q == C_ID)
               begin
                  ph_q <= PH_TX;
                  id_idx_q <= 2'h0;
                  tx_q <= DEVICE_ID[23:16];
                  drive_low_q <= ~DEVICE_ID[23];
                  bit_q <= 4'h1;
               end
            end
         end
         else if (ph_q == PH_TX)
         begin
            if (scl_rise && bit_q == 4'h9)
               master_ack_q <= ~sda_s_q[1];
            else if (scl_fall && bit_q < 4'h8)
            begin
               tx_q <= {tx_q[6:0], 1'b1};
               drive_low_q <= ~tx_q[6];
               bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall && bit_q == 4'h8)
            begin
               drive_low_q <= 1'b0;
               bit_q <= 4'h9;
            end
            else if (scl_fall && bit_q == 4'h9)
            begin
               // RQ15 ack wraps, nack ends
               if (master_ack_q)
               begin
                  tx_q <= id_byte;
                  drive_low_q <= ~id_byte[7];
                  bit_q <= 4'h1;
               end
               else
               begin
                  ph_q <= PH_IDLE;
                  cmd_q <= C_NONE;
               end
            end
            else if (scl_rise && bit_q == 4'h8)
               id_idx_q <= (id_idx_q == `ID_BYTES - 2'h1) ? 2'h0 :
                           id_idx_q + 2'h1;
         end
      end
   end

   // open drain: only ever pull low
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~drive_low_q;

endmodule

// ---- verification/i2c_sleep_id_assertions.sv ----
`timescale 1ns/100ps
module i2c_sleep_id_assertions #(
   parameter TREC_CYCLES = 10000
)(
   input wire ref_clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_n,
   input wire address_select_low,
   input wire address_select_high,
   input wire regulator_on_q,
   input wire sleeping_q,
   input wire recovering_q
);
   reg [31:0] rec_cnt_q;
   reg [7:0]  ack_age_q;
   // saturating so an old ack never looks recent
   always @(posedge ref_clk)
   begin
      rec_cnt_q <= (rst || !recovering_q) ? 32'h0 : rec_cnt_q + 32'h1;
      ack_age_q <= (rst || !sda_oe_n) ? 8'h0 :
                   ack_age_q + {7'h0, ack_age_q != 8'hFF};
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_sleep_reg_off: assert property (sleeping_q |-> !regulator_on_q)
      else $error("regulator on in sleep");
   chk_sleep_entry: assert property ($rose(sleeping_q) |-> ack_age_q < 8'h0C)
      else $error("sleep without ack");
   chk_sleep_no_ack: assert property (sleeping_q && $past(sleeping_q, 8) |-> sda_oe_n)
      else $error("ack while asleep");
   chk_wake_from_sleep: assert property ($rose(recovering_q) |-> $past(sleeping_q))
      else $error("recovery not from sleep");
   chk_rec_no_ack: assert property (recovering_q |-> sda_oe_n)
      else $error("ack during recovery");
   chk_rec_min_len: assert property ($fell(recovering_q) |-> rec_cnt_q >= TREC_CYCLES - 1)
      else $error("recovery too short");
   chk_rec_max_len: assert property (recovering_q |-> rec_cnt_q <= TREC_CYCLES + 1)
      else $error("recovery too long");
   chk_standby_after: assert property ($fell(recovering_q) |-> !sleeping_q && regulator_on_q)
      else $error("no standby after recovery");
   chk_sleep_exit_path: assert property ($fell(sleeping_q) |-> recovering_q || $past(recovering_q))
      else $error("sleep left without wake");
endmodule
bind i2c_sleep_id i2c_sleep_id_assertions #(.TREC_CYCLES(TREC_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .address_select_low(address_select_low),
   .address_select_high(address_select_high),
   .regulator_on_q(regulator_on_q), .sleeping_q(sleeping_q),
   .recovering_q(recovering_q));

// ---- verification/i2c_master_model.sv ----
`timescale 1ns/100ps
module i2c_master_model (
   input  wire ref_clk,
   input  wire sda,
   output reg  scl,
   output reg  sda_low
);
   initial
   begin
      scl <= 1'b1;
      sda_low <= 1'b0;
   end
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task seq(input s1, input s2);
   begin
      cyc(3);
      sda_low <= s1;
      cyc(2);
      scl <= 1'b1;
      cyc(2);
      sda_low <= s2;
   end
   endtask
   task start_c;
   begin
      seq(1'b0, 1'b1);
      cyc(2);
      scl <= 1'b0;
   end
   endtask
   task stop_c;
      seq(1'b1, 1'b0);
   endtask
   task bit_x(input b, output r);
   begin
      cyc(3);
      sda_low <= !b;
      cyc(2);
      scl <= 1'b1;
      cyc(2);
      @(negedge ref_clk);
      r = sda;
      @(posedge ref_clk);
      scl <= 1'b0;
   end
   endtask
   task wr(input [7:0] d, output ack);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = !r;
   end
   endtask
   task rd(input ack, output [7:0] d);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         bit_x(1'b1, d[i]);
      bit_x(!ack, r);
   end
   endtask
   // clock until data reads high, then start and stop
   task recover;
      integer k;
      reg     r;
   begin
      k = 0;
      r = 1'b0;
      while (k < 9 && !r)
      begin
         bit_x(1'b1, r);
         k = k + 1;
      end
      start_c;
      stop_c;
   end
   endtask
endmodule

// ---- verification/i2c_sleep_id_test.sv ----
`timescale 1ns/100ps
`include "i2c_sleep_id_defs.vh"
module i2c_sleep_id_test;
   // arbitrary identifier value
   localparam [23:0] ID   = 24'h5A3CE1;
   localparam        TREC = 200;
   reg         ref_clk, rst, sel_lo, sel_hi, a;
   reg  [7:0]  d, adr;
   integer     i, n_fail, total_checks;
   wire        scl, sda_low, sda_oe_n, sda_dev, reg_on, sleeping, recovering;
   // pull-up: high unless either side pulls low
   wire        sda = (sda_oe_n | sda_dev) & !sda_low;
   i2c_sleep_id #(.TREC_CYCLES(TREC), .DEVICE_ID(ID)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_dev), .sda_oe_n(sda_oe_n), .address_select_low(sel_lo),
      .address_select_high(sel_hi), .regulator_on_q(reg_on),
      .sleeping_q(sleeping), .recovering_q(recovering));
   i2c_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl),
      .sda_low(sda_low));
   always #20 ref_clk = !ref_clk;
   task check(input string nm, input [23:0] seen, input [23:0] exp);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task summarize;
   begin
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // random top bit and rw must not matter
   function [7:0] aw(input [1:0] x);
      aw = {`DEV_TYPE_CODE, sel_hi, sel_lo, x};
   endfunction
   task pre(input [7:0] w);
   begin
      m.start_c;
      m.wr(`RESERVED_SLAVE_BYTE, a);
      check("f8 ack", a, 1);
      m.wr(w, a);
      check("adr ack", a, 1);
      m.start_c;
   end
   endtask
   task id_read;
   begin
      pre(aw($urandom));
      m.wr(`ID_READ_BYTE, a);
      check("f9 ack", a, 1);
      for (i = 0; i < 4; i = i + 1)
      begin
         m.rd(i < 3, d);
         check("id byte", d, ID[23 - 8 * (i % 3) -: 8]);
      end
      m.stop_c;
   end
   endtask
   initial
   begin
      ref_clk = 1'b0;
      rst <= 1'b1;
      {sel_lo, sel_hi} <= 2'h0;
      n_fail = 0;
      total_checks = 0;
      i = $urandom(42925);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      sel_lo <= $urandom;
      sel_hi <= $urandom;
      repeat (4) @(posedge ref_clk);
      id_read;
      m.start_c;
      m.wr(`RESERVED_SLAVE_BYTE, a);
      m.wr(aw($urandom) ^ 8'h0C, a);
      check("bad sel", a, 0);
      m.stop_c;
      m.start_c;
      m.wr(`RESERVED_SLAVE_BYTE, a);
      m.start_c;
      m.wr(`ID_READ_BYTE, a);
      check("aborted", a, 0);
      m.stop_c;
      // readout cut where the next two id bits are ones
      pre(aw($urandom));
      m.wr(`ID_READ_BYTE, a);
      for (i = 0; i < 3; i = i + 1)
         m.bit_x(1'b1, a);
      m.recover;
      check("bus free", sda_oe_n, 1);
      id_read;
      pre(aw($urandom));
      m.wr(`SLEEP_CMD_BYTE, a);
      check("86 ack", a, 1);
      m.stop_c;
      check("sleep", {sleeping, reg_on}, 2'h2);
      m.start_c;
      m.wr(`RESERVED_SLAVE_BYTE, a);
      m.stop_c;
      check("asleep", {a, sleeping}, 2'h1);
      m.start_c;
      m.wr(aw($urandom), a);
      m.stop_c;
      check("recovering", recovering, 1);
      m.start_c;
      m.wr(`RESERVED_SLAVE_BYTE, a);
      check("busy ack", a, 0);
      m.stop_c;
      repeat (TREC) @(posedge ref_clk);
      check("standby", {recovering, sleeping, reg_on}, 3'h1);
      id_read;
      summarize;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail = n_fail + 1;
      summarize;
   end
endmodule
